// File: hdl/rtcc_defines.svh
// Contract
// - minutes held BCD 00-59 in bits 6:0
// - hours held BCD 00-23 in bits 5:0
// - day of month BCD 01-31 in bits 5:0
// - february gets day 29 when year divisible by four
// - weekday counts 0-6, sunday is zero
// - weekday only counts cyclically, meaning is software's
// - century bit inverts on year 99 to 00
// - century zero means 20xx, one means 19xx
// - month held BCD 01-12 in bits 4:0
// - year held eight-bit BCD 00-99
// - alarm bit 7 set drops field from compare
// - alarm flag sets when enabled fields first match
// - flag holds until cleared, resets only on new match
// - alarm fields are BCD at documented bit ranges
// - clock output enable zero floats the pin
// - select picks 32768, 1024, 32 or 1 Hz
// - seconds BCD in bits 6:0, bit 7 validity
// - writing zero clears alarm flag, one keeps it
// - stop zeroes divider, halts time, 32 kHz stays
`ifndef RTCC_DEFINES_SVH
`define RTCC_DEFINES_SVH

// register byte addresses
`define RTCC_ADDR_SEC    8'h02
`define RTCC_ADDR_MIN    8'h03
`define RTCC_ADDR_HOUR   8'h04
`define RTCC_ADDR_DAY    8'h05
`define RTCC_ADDR_WDAY   8'h06
`define RTCC_ADDR_MON    8'h07
`define RTCC_ADDR_YEAR   8'h08
`define RTCC_ADDR_AMIN   8'h09
`define RTCC_ADDR_AHOUR  8'h0a
`define RTCC_ADDR_ADAY   8'h0b
`define RTCC_ADDR_AWDAY  8'h0c
`define RTCC_ADDR_CLKCTL 8'h0d

// field positions
`define RTCC_BIT_TOP     7
`define RTCC_FLD_ZERO    8'h00

// BCD limits
`define RTCC_BCD_59      7'h59
`define RTCC_BCD_23      6'h23
`define RTCC_BCD_12      5'h12
`define RTCC_BCD_99      8'h99
`define RTCC_WDAY_LAST   3'h6
`define RTCC_MON_FEB     5'h02
`define RTCC_DAY_28      8'h28
`define RTCC_DAY_29      8'h29
`define RTCC_DAY_30      8'h30
`define RTCC_DAY_31      8'h31

// reset values
`define RTCC_RST_DAY     6'h01
`define RTCC_RST_MON     5'h01
`define RTCC_RST_FD      2'h0

// divider chain: 15 stages from the 32768 Hz edge
`define RTCC_DIV_LAST    15'h7fff
`define RTCC_DIV_1024    4
`define RTCC_DIV_32      9
`define RTCC_DIV_1       14

`endif

// File: hdl/rtcc_pkg.sv
package rtcc_pkg;

    // byte-wide register access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } rtcc_req_t;

    // clock output pin, split into level and enable
    typedef struct packed {
        logic level;
        logic oe;
    } rtcc_pin_t;

    typedef enum logic [1:0] {
        RTCC_FD_32K,
        RTCC_FD_1024,
        RTCC_FD_32,
        RTCC_FD_1
    } rtcc_fd_t;

endpackage

// File: hdl/rtcc_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defines.svh"

module rtcc_core (
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_ce,
    input  wire logic              i_osc_32k,
    input  wire logic              i_stop,
    input  wire rtcc_pkg::rtcc_req_t i_req,
    input  wire logic              i_flag_wr,
    input  wire logic              i_flag_wr_val,
    output var  logic [7:0]        o_rdata,
    output var  logic              o_rd_valid,
    output var  logic              o_alarm_hit_flag,
    output var  rtcc_pkg::rtcc_pin_t o_clock_output_pin
);
    import rtcc_pkg::*;

    // ==========================================================
    // helpers
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    // BCD year divisible by four, year 00 included
    function automatic logic is_leap(input logic [7:0] y);
        if (y[4] == 1'b0) begin
            is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
        end else begin
            is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        end
    endfunction

    // last day of a month in BCD
    function automatic logic [7:0] month_last(input logic [4:0] m, input logic [7:0] y);
        case (m)
            `RTCC_MON_FEB: month_last = is_leap(y) ? `RTCC_DAY_29 : `RTCC_DAY_28;
            5'h04, 5'h06, 5'h09, 5'h11: month_last = `RTCC_DAY_30;
            default: month_last = `RTCC_DAY_31;
        endcase
    endfunction

    function automatic logic wr_at(input rtcc_req_t r, input logic [7:0] a);
        wr_at = r.wr && (r.addr == a);
    endfunction

    // ==========================================================
    // oscillator sync and divider chain
    logic        osc_s1_q;
    logic        osc_s2_q;
    logic        osc_s3_q;
    logic [14:0] div_q;
    logic        osc_rise;
    logic        sec_tick;

    // two flops before use; third only for edge detect
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else if (i_ce) begin
            osc_s1_q <= i_osc_32k;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    assign osc_rise = osc_s2_q && !osc_s3_q;
    assign sec_tick = osc_rise && !i_stop && (div_q == `RTCC_DIV_LAST);

    // stop holds every stage at zero, so time freezes
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            div_q <= 15'h0000;
        end else if (i_ce) begin
            if (i_stop) begin
                div_q <= 15'h0000;
            end else if (osc_rise) begin
                div_q <= div_q + 15'h0001;
            end
        end
    end

    // ==========================================================
    // time and date counters
    logic [6:0] sec_q;
    logic       valid_low_q;
    logic [6:0] min_q;
    logic [5:0] hour_q;
    logic [5:0] day_q;
    logic [2:0] wday_q;
    logic [4:0] mon_q;
    logic       cent_q;
    logic [7:0] year_q;

    logic       c_min;
    logic       c_hour;
    logic       c_day;
    logic       c_mon;
    logic       c_year;
    logic       c_cent;
    logic [7:0] last_day;

    // carry chain, each stage wraps at its BCD limit
    always_comb begin
        last_day = month_last(mon_q, year_q);
        c_min    = sec_tick && (sec_q == `RTCC_BCD_59);
        c_hour   = c_min && (min_q == `RTCC_BCD_59);
        c_day    = c_hour && (hour_q == `RTCC_BCD_23);
        c_mon    = c_day && ({2'b00, day_q} == last_day);
        c_year   = c_mon && (mon_q == `RTCC_BCD_12);
        c_cent   = c_year && (year_q == `RTCC_BCD_99);
    end

    // host writes win over a tick in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            sec_q       <= 7'h00;
            valid_low_q <= 1'b1;
            min_q       <= 7'h00;
            hour_q      <= 6'h00;
            day_q       <= `RTCC_RST_DAY;
            wday_q      <= 3'h0;
            mon_q       <= `RTCC_RST_MON;
            cent_q      <= 1'b0;
            year_q      <= 8'h00;
        end else if (i_ce) begin
            if (wr_at(i_req, `RTCC_ADDR_SEC)) begin
                sec_q       <= i_req.data[6:0];
                valid_low_q <= i_req.data[`RTCC_BIT_TOP];
            end else if (sec_tick) begin
                sec_q <= c_min ? 7'h00 : 7'(bcd_inc({1'b0, sec_q}));
            end
            if (wr_at(i_req, `RTCC_ADDR_MIN)) begin
                min_q <= i_req.data[6:0];
            end else if (c_min) begin
                min_q <= c_hour ? 7'h00 : 7'(bcd_inc({1'b0, min_q}));
            end
            if (wr_at(i_req, `RTCC_ADDR_HOUR)) begin
                hour_q <= i_req.data[5:0];
            end else if (c_hour) begin
                hour_q <= c_day ? 6'h00 : 6'(bcd_inc({2'b00, hour_q}));
            end
            if (wr_at(i_req, `RTCC_ADDR_DAY)) begin
                day_q <= i_req.data[5:0];
            end else if (c_day) begin
                day_q <= c_mon ? `RTCC_RST_DAY : 6'(bcd_inc({2'b00, day_q}));
            end
            // weekday is a pure modulo-7 counter
            if (wr_at(i_req, `RTCC_ADDR_WDAY)) begin
                wday_q <= i_req.data[2:0];
            end else if (c_day) begin
                wday_q <= (wday_q == `RTCC_WDAY_LAST) ? 3'h0 : wday_q + 3'h1;
            end
            if (wr_at(i_req, `RTCC_ADDR_MON)) begin
                mon_q  <= i_req.data[4:0];
                cent_q <= i_req.data[`RTCC_BIT_TOP];
            end else begin
                if (c_mon) begin
                    mon_q <= c_year ? `RTCC_RST_MON : 5'(bcd_inc({3'b000, mon_q}));
                end
                if (c_cent) begin
                    cent_q <= !cent_q;
                end
            end
            if (wr_at(i_req, `RTCC_ADDR_YEAR)) begin
                year_q <= i_req.data;
            end else if (c_year) begin
                year_q <= c_cent ? 8'h00 : bcd_inc(year_q);
            end
        end
    end

    // ==========================================================
    // alarm compare and flag
    logic [7:0] amin_q;
    logic [7:0] ahour_q;
    logic [7:0] aday_q;
    logic [7:0] awday_q;
    logic       match;
    logic       match_q;
    logic       alarm_rise;
    logic       flag_clear;

    // alarm fields reset disabled, so all fields match right after reset
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            amin_q  <= 8'h80;
            ahour_q <= 8'h80;
            aday_q  <= 8'h80;
            awday_q <= 8'h80;
        end else if (i_ce) begin
            if (wr_at(i_req, `RTCC_ADDR_AMIN)) begin
                amin_q <= {i_req.data[7], i_req.data[6:0]};
            end
            if (wr_at(i_req, `RTCC_ADDR_AHOUR)) begin
                ahour_q <= {i_req.data[7], 1'b0, i_req.data[5:0]};
            end
            if (wr_at(i_req, `RTCC_ADDR_ADAY)) begin
                aday_q <= {i_req.data[7], 1'b0, i_req.data[5:0]};
            end
            if (wr_at(i_req, `RTCC_ADDR_AWDAY)) begin
                awday_q <= {i_req.data[7], 4'h0, i_req.data[2:0]};
            end
        end
    end

    // a disabled field always counts as matching
    assign match = (amin_q[7]  || (amin_q[6:0]  == min_q))  &&
                   (ahour_q[7] || (ahour_q[5:0] == hour_q)) &&
                   (aday_q[7]  || (aday_q[5:0]  == day_q))  &&
                   (awday_q[7] || (awday_q[2:0] == wday_q));
    assign alarm_rise = match && !match_q;
    assign flag_clear = i_flag_wr && !i_flag_wr_val;

    // edge on match keeps a lingering match from re-arming
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            match_q          <= 1'b0;
            o_alarm_hit_flag <= 1'b0;
        end else if (i_ce) begin
            match_q <= match;
            if (alarm_rise) begin
                o_alarm_hit_flag <= 1'b1;
            end else if (flag_clear) begin
                o_alarm_hit_flag <= 1'b0;
            end
        end
    end

    // ==========================================================
    // clock output
    logic     fe_q;
    rtcc_fd_t fd_q;
    logic     clk_sel;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            fe_q <= 1'b1;
            fd_q <= RTCC_FD_32K;
        end else if (i_ce && wr_at(i_req, `RTCC_ADDR_CLKCTL)) begin
            fe_q <= i_req.data[`RTCC_BIT_TOP];
            fd_q <= rtcc_fd_t'(i_req.data[1:0]);
        end
    end

    // 32 kHz comes from the synchronised oscillator, not the divider
    always_comb begin
        case (fd_q)
            RTCC_FD_32K:  clk_sel = osc_s2_q;
            RTCC_FD_1024: clk_sel = div_q[`RTCC_DIV_1024];
            RTCC_FD_32:   clk_sel = div_q[`RTCC_DIV_32];
            RTCC_FD_1:    clk_sel = div_q[`RTCC_DIV_1];
            default:      clk_sel = osc_s2_q;
        endcase
    end

    // level parked low while floating
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_clock_output_pin <= '0;
        end else if (i_ce) begin
            o_clock_output_pin.oe    <= fe_q;
            o_clock_output_pin.level <= fe_q && clk_sel;
        end
    end

    // ==========================================================
    // register readback; unmapped and meaningless bits read zero
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_rdata    <= `RTCC_FLD_ZERO;
            o_rd_valid <= 1'b0;
        end else if (i_ce) begin
            o_rd_valid <= i_req.rd;
            if (i_req.rd) begin
                case (i_req.addr)
                    `RTCC_ADDR_SEC:    o_rdata <= {valid_low_q, sec_q};
                    `RTCC_ADDR_MIN:    o_rdata <= {1'b0, min_q};
                    `RTCC_ADDR_HOUR:   o_rdata <= {2'b00, hour_q};
                    `RTCC_ADDR_DAY:    o_rdata <= {2'b00, day_q};
                    `RTCC_ADDR_WDAY:   o_rdata <= {5'h00, wday_q};
                    `RTCC_ADDR_MON:    o_rdata <= {cent_q, 2'b00, mon_q};
                    `RTCC_ADDR_YEAR:   o_rdata <= year_q;
                    `RTCC_ADDR_AMIN:   o_rdata <= amin_q;
                    `RTCC_ADDR_AHOUR:  o_rdata <= ahour_q;
                    `RTCC_ADDR_ADAY:   o_rdata <= aday_q;
                    `RTCC_ADDR_AWDAY:  o_rdata <= awday_q;
                    `RTCC_ADDR_CLKCTL: o_rdata <= {fe_q, 5'h00, fd_q};
                    default:           o_rdata <= `RTCC_FLD_ZERO;
                endcase
            end
        end
    end

    // ==========================================================
    // checks
    logic no_wr;
    assign no_wr = !i_req.wr;

    sec_wrap_a:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_ce && no_wr && sec_tick && (sec_q == `RTCC_BCD_59)
        |=> (sec_q == 7'h00) && (min_q != $past(min_q)))
    else $error("second rollover did not carry into minute");

    leap_day_a:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_ce && no_wr && c_day && (mon_q == `RTCC_MON_FEB) && (day_q == 6'h28)
        && is_leap(year_q) |=> (day_q == 6'h29) && (mon_q == `RTCC_MON_FEB))
    else $error("leap february skipped day 29");

    century_flip_a:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_ce && no_wr && c_cent |=> (cent_q != $past(cent_q)) && (year_q == 8'h00))
    else $error("century bit did not invert at year wrap");

    wday_wrap_a:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_ce && no_wr && c_day && (wday_q == `RTCC_WDAY_LAST) |=> (wday_q == 3'h0))
    else $error("weekday did not wrap to zero");

    alarm_set_a:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_ce && alarm_rise |=> o_alarm_hit_flag)
    else $error("alarm flag not set on first match");

    alarm_hold_a:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !o_alarm_hit_flag ##1 (i_ce && match && $past(match) && !$past(alarm_rise))
        |=> !o_alarm_hit_flag)
    else $error("alarm flag rose on a persisting match");

    flag_clear_a:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_ce && i_flag_wr && !alarm_rise |=> (o_alarm_hit_flag == $past(o_alarm_hit_flag && i_flag_wr_val)))
    else $error("alarm flag write gave the wrong result");

    stop_hold_a:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_ce && i_stop |=> (div_q == 15'h0000) && !sec_tick)
    else $error("divider ran while stopped");

    clk_float_a:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_ce && !fe_q |=> !o_clock_output_pin.oe && !o_clock_output_pin.level)
    else $error("clock output driven while disabled");

endmodule

`default_nettype wire

// File: dv/rtcc_osc_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// crystal oscillator stand-in
module rtcc_osc_model (
    input  wire logic i_clk,
    output var  logic o_osc
);
    // free-running, two clk periods per cycle, so a whole second fits
    // the run budget; each level is still sampled exactly once
    logic phase_q = 1'b0;

    // moves on the falling edge so it never races the design's sampling
    always_ff @(negedge i_clk) begin
        phase_q <= !phase_q;
    end

    always_comb begin
        o_osc = phase_q;
    end
endmodule

`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import rtcc_pkg::*;

    logic       i_clk;
    logic       i_reset_n;
    logic       i_ce;
    logic       i_stop;
    logic       i_osc_32k;
    rtcc_req_t  i_req;
    logic       i_flag_wr;
    logic       i_flag_wr_val;
    logic [7:0] o_rdata;
    logic       o_rd_valid;
    logic       o_alarm_hit_flag;
    rtcc_pin_t  o_pin;
    int         err_count;
    int         cmp_count;

    // ==========================================================
    // clock, partner and device
    always #4 i_clk = ~i_clk;

    rtcc_osc_model i_rtcc_osc_model (.i_clk(i_clk), .o_osc(i_osc_32k));

    rtcc_core i_rtcc_core (
        .i_clk              (i_clk),
        .i_reset_n          (i_reset_n),
        .i_ce               (i_ce),
        .i_osc_32k          (i_osc_32k),
        .i_stop             (i_stop),
        .i_req              (i_req),
        .i_flag_wr          (i_flag_wr),
        .i_flag_wr_val      (i_flag_wr_val),
        .o_rdata            (o_rdata),
        .o_rd_valid         (o_rd_valid),
        .o_alarm_hit_flag   (o_alarm_hit_flag),
        .o_clock_output_pin (o_pin)
    );

    // ==========================================================
    // compare and report
    task automatic fail(input string msg);
        $display("unexpected at %0t: %s", $time, msg);
        err_count++;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) fail($sformatf("%s got %h want %h", msg, got, exp));
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        cmp_count++;
        if (got !== exp) fail(msg);
    endtask

    // counts come from the bench, so a plain int range is enough
    task automatic chk_count(input int got, input int lo, input int hi, input string msg);
        cmp_count++;
        if (got < lo || got > hi) fail($sformatf("%s count %0d", msg, got));
    endtask

    task automatic end_of_test();
        $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================================
    // register and flag access, all changes on the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_req = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(negedge i_clk);
        i_req = '0;
    endtask

    // read valid stands only in the cycle after the edge that takes the strobe; data holds until the next read
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_clk);
        i_req = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(negedge i_clk);
        i_req = '0;
        chk_bit(o_rd_valid, 1'b1, "read strobe missing");
        chk_byte(o_rdata, exp, $sformatf("read %h", a));
    endtask

    task automatic flag_wr(input logic v);
        @(negedge i_clk);
        i_flag_wr     = 1'b1;
        i_flag_wr_val = v;
        @(negedge i_clk);
        i_flag_wr     = 1'b0;
        i_flag_wr_val = 1'b1;
    endtask

    task automatic wait_flag(input int bound);
        int i;
        for (i = 0; i < bound && o_alarm_hit_flag !== 1'b1; i++) @(negedge i_clk);
        chk_bit(o_alarm_hit_flag, 1'b1, "alarm flag not set");
        if (o_alarm_hit_flag !== 1'b1) end_of_test();
    endtask

    task automatic count_rises(input int n, output int c);
        logic last;
        last = o_pin.level;
        c    = 0;
        repeat (n) begin
            @(negedge i_clk);
            if (o_pin.level === 1'b1 && last === 1'b0) c++;
            last = o_pin.level;
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset_values();
        logic [7:0] addrs[13] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                                  8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e};
        logic [7:0] vals[13]  = '{8'h80, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00,
                                  8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00};
        foreach (addrs[i]) rd_chk(addrs[i], vals[i]);
        wr(8'h0e, 8'h5a);
        rd_chk(8'h0e, 8'h00); // unmapped place stays empty
        $display("test reset_values done");
    endtask

    // irrelevant bits are dropped, meaningful ones stored as written
    task automatic t_fields();
        logic [7:0] addrs[8] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0a, 8'h0c};
        logic [7:0] data[8]  = '{8'hd9, 8'he3, 8'hf1, 8'hfe, 8'hf2, 8'h99, 8'he3, 8'hff};
        logic [7:0] vals[8]  = '{8'h59, 8'h23, 8'h31, 8'h06, 8'h92, 8'h99, 8'ha3, 8'h87};
        foreach (addrs[i]) begin
            wr(addrs[i], data[i]);
            rd_chk(addrs[i], vals[i]);
        end
        $display("test fields done");
    endtask

    task automatic t_alarm();
        wr(8'h0a, 8'h80);
        wr(8'h0b, 8'h80);
        wr(8'h0c, 8'h80);
        wr(8'h09, 8'h10);
        flag_wr(1'b0);
        repeat (3) @(negedge i_clk);
        chk_bit(o_alarm_hit_flag, 1'b0, "flag set without match");
        wr(8'h03, 8'h10);
        wait_flag(3);
        flag_wr(1'b1);
        chk_bit(o_alarm_hit_flag, 1'b1, "writing one disturbed flag");
        flag_wr(1'b0);
        chk_bit(o_alarm_hit_flag, 1'b0, "writing zero kept flag");
        repeat (8) @(negedge i_clk);
        chk_bit(o_alarm_hit_flag, 1'b0, "persisting match re-set flag");
        wr(8'h0a, 8'h05);
        repeat (3) @(negedge i_clk);
        chk_bit(o_alarm_hit_flag, 1'b0, "hour mismatch ignored");
        wr(8'h0a, 8'h85);
        wait_flag(3);
        flag_wr(1'b0);
        $display("test alarm done");
    endtask

    task automatic t_clock_output_pin();
        int c;
        chk_bit(o_pin.oe, 1'b1, "clock output off after reset");
        count_rises(400, c);
        chk_count(c, 199, 201, "32k");
        i_ce = 1'b0;
        count_rises(64, c);
        chk_count(c, 0, 0, "output ran with clock enable low");
        i_ce = 1'b1;
        wr(8'h0d, 8'h00);
        repeat (3) @(negedge i_clk);
        chk_bit(o_pin.oe, 1'b0, "pin driven while disabled");
        count_rises(64, c);
        chk_count(c, 0, 0, "disabled pin");
        wr(8'h0d, 8'h81);
        repeat (3) @(negedge i_clk);
        count_rises(1280, c);
        chk_count(c, 19, 21, "1024");
        wr(8'h0d, 8'h82);
        repeat (3) @(negedge i_clk);
        count_rises(8192, c);
        chk_count(c, 3, 5, "32");
        @(negedge i_clk);
        i_stop = 1'b1;
        wr(8'h0d, 8'h81);
        count_rises(1280, c);
        chk_count(c, 0, 0, "divider ran while stopped");
        wr(8'h0d, 8'h80);
        repeat (3) @(negedge i_clk);
        count_rises(400, c);
        chk_count(c, 199, 201, "32k while stopped");
        i_stop = 1'b0;
        $display("test clock_output_pin done");
    endtask

    // one real second: last moment of the century ripples into the next
    task automatic t_tick();
        logic [7:0] wa[12] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                               8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
        logic [7:0] wd[12] = '{8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12, 8'h99,
                               8'h00, 8'h80, 8'h80, 8'h80, 8'h83};
        logic [7:0] ra[7]  = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
        logic [7:0] rv[7]  = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h81, 8'h00};
        int c;
        foreach (wa[i]) wr(wa[i], wd[i]);
        flag_wr(1'b0);
        chk_bit(o_alarm_hit_flag, 1'b0, "flag before tick");
        // the slow output is watched while waiting for the second to pass
        count_rises(65000, c);
        wait_flag(2000);
        chk_count(c, 1, 1, "1 Hz");
        foreach (ra[i]) rd_chk(ra[i], rv[i]);
        flag_wr(1'b0);
        repeat (16) @(negedge i_clk);
        chk_bit(o_alarm_hit_flag, 1'b0, "flag re-set on held match");
        $display("test tick done");
    endtask

    // ==========================================================
    // main sequence
    initial begin
        i_clk         = 1'b0;
        i_reset_n     = 1'b0;
        i_ce          = 1'b1;
        i_stop        = 1'b0;
        i_req         = '0;
        i_flag_wr     = 1'b0;
        i_flag_wr_val = 1'b1;
        err_count     = 0;
        cmp_count     = 0;
        repeat (4) @(negedge i_clk);
        i_reset_n = 1'b1;
        // all fields disabled means a match right after reset
        flag_wr(1'b0);
        t_reset_values();
        t_fields();
        t_alarm();
        t_clock_output_pin();
        t_tick();
        end_of_test();
    end
endmodule

`default_nettype wire
